// ---- design/pie_map.vh ----
/*
  register map, field positions and reset values of the waveform generator
  interrupt enable block.
  assumes: included by bare name from the design files under design/.
*/
`ifndef PIE_MAP_VH
`define PIE_MAP_VH

// bus geometry
`define PIE_ADDR_W          12
`define PIE_DATA_W          32

// register offsets (byte addresses)
`define PIE_OFS_DIRECT      12'h300
`define PIE_OFS_SET         12'h304
`define PIE_OFS_CLEAR       12'h308
`define PIE_OFS_STATUS      12'h30C
`define PIE_OFS_LOOPS       12'h310

// event bit positions, shared by the enable and status views
`define PIE_BIT_HALTED      1
`define PIE_BIT_BEGUN0      2
`define PIE_BIT_BEGUN1      3
`define PIE_BIT_FINISH0     4
`define PIE_BIT_FINISH1     5
`define PIE_BIT_PERIOD      6
`define PIE_BIT_LOOPS       7
`define PIE_BIT_LO          1
`define PIE_BIT_HI          7
`define PIE_NUM_EVT         7

// implemented bits of the event layout; bit 0 and bits 31:8 read zero
`define PIE_EVT_MASK        32'h000000FE

// reset values
`define PIE_RST_ENABLE      7'h00
`define PIE_RST_STATUS      7'h00
`define PIE_RST_LOOPS       16'h0000
`define PIE_RST_DATA        32'h00000000

// repeat count field
`define PIE_LOOPS_W         16

`endif

// ---- design/pie_event_latch.v ----
/*
  sticky event flags, one per event, set by a hardware pulse and cleared
  as a group by a read of the status register.
  assumes: events and the clear strobe are single-cycle pulses on mclk.
*/
`timescale 1ns/1ps
`include "pie_map.vh"

module pie_event_latch #(
  parameter N = `PIE_NUM_EVT
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [N-1:0] evt,
  input  wire         clear,
  output wire [N-1:0] flag
);

  localparam [N-1:0] RST_FLAG = `PIE_RST_STATUS;

  ////////////////////////////////////////////////////////////////////////////
  // a new event in the clearing cycle survives the clear; each flag is its
  // own flop so that every register has a single driving process
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_flag
      reg sticky;

      always @(posedge mclk) begin
        if (rst)
          sticky <= RST_FLAG[i];
        else if (evt[i])
          sticky <= 1'b1;
        else if (clear)
          sticky <= 1'b0;
      end

      assign flag[i] = sticky;
    end
  endgenerate

endmodule // pie_event_latch

// ---- design/pie_loop_tracker.v ----
/*
  counts completions of the second sequence during a looped playback and
  pulses loops_done after the last one.
  assumes: play_start and seq1_done are single-cycle pulses on mclk from
  the sequencer; loop_count is stable software state.
*/
`timescale 1ns/1ps
`include "pie_map.vh"

module pie_loop_tracker #(
  parameter LW = `PIE_LOOPS_W
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire          play_start,
  input  wire          seq1_done,
  input  wire [LW-1:0] loop_count,
  output reg           loops_done
);

  reg [LW-1:0] remaining;
  reg          armed;

  ////////////////////////////////////////////////////////////////////////////
  // the count is captured at playback start; later writes do not disturb
  // a playback already running
  always @(posedge mclk) begin
    if (rst) begin
      remaining  <= {LW{1'b0}};
      armed      <= 1'b0;
      loops_done <= 1'b0;
    end else begin
      loops_done <= 1'b0;
      if (play_start) begin
        remaining <= loop_count;
        armed     <= (loop_count != {LW{1'b0}});
      end else if (seq1_done && armed) begin
        if (remaining == {{(LW-1){1'b0}}, 1'b1}) begin
          armed      <= 1'b0;
          loops_done <= 1'b1;
        end
        remaining <= remaining - {{(LW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // pie_loop_tracker

// ---- design/pie_top.v ----
/*
  interrupt enable block of the waveform generator: the enable mask with
  its direct, set and clear views, sticky event status cleared on read,
  the looped-playback completion event and the interrupt output.
  assumes: one clock mclk at 50 MHz, synchronous active-high rst, event
  pulses from sequencer logic on the same clock, a simple register port
  whose strobes are one cycle long and never both high.
*/
`timescale 1ns/1ps
`include "pie_map.vh"

module pie_top #(
  parameter AW = `PIE_ADDR_W,
  parameter DW = `PIE_DATA_W,
  parameter LW = `PIE_LOOPS_W
) (
  input  wire          mclk,
  input  wire          rst,
  // register port
  input  wire [AW-1:0] reg_addr,
  input  wire [DW-1:0] reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [DW-1:0] reg_rdata,
  // event pulses from the generator
  input  wire          halted_event,
  input  wire [1:0]    sequence_begun_event,
  input  wire [1:0]    sequence_finished_event,
  input  wire          period_finished_event,
  input  wire          playback_start,
  // derived event, enable state and interrupt
  output wire          loops_completed_event,
  output wire [6:0]    enable_state,
  output wire          irq
);

  ////////////////////////////////////////////////////////////////////////////
  // event positions and read-word padding

  localparam NE         = `PIE_NUM_EVT;
  localparam IX_HALTED  = `PIE_BIT_HALTED - `PIE_BIT_LO;
  localparam IX_BEGUN0  = `PIE_BIT_BEGUN0 - `PIE_BIT_LO;
  localparam IX_BEGUN1  = `PIE_BIT_BEGUN1 - `PIE_BIT_LO;
  localparam IX_FINISH0 = `PIE_BIT_FINISH0 - `PIE_BIT_LO;
  localparam IX_FINISH1 = `PIE_BIT_FINISH1 - `PIE_BIT_LO;
  localparam IX_PERIOD  = `PIE_BIT_PERIOD - `PIE_BIT_LO;
  localparam IX_LOOPS   = `PIE_BIT_LOOPS - `PIE_BIT_LO;
  localparam PAD_HI     = DW - `PIE_BIT_HI - 1;
  localparam PAD_LO     = `PIE_BIT_LO;
  localparam PAD_LOOPS  = DW - LW;

  localparam [NE-1:0] RST_ENABLE = `PIE_RST_ENABLE;

  ////////////////////////////////////////////////////////////////////////////
  // state

  wire [NE-1:0] enable;
  reg  [LW-1:0] loop_count;
  reg  [DW-1:0] next_rdata;

  wire [NE-1:0] evt_vec;
  wire [NE-1:0] status;
  wire [NE-1:0] pending;
  wire [NE-1:0] wbits;
  wire [NE-1:0] set_bits;
  wire [NE-1:0] clear_bits;
  wire [DW-1:0] view_mask;
  wire [DW-1:0] view_status;
  wire [DW-1:0] view_loops;
  wire          status_read;
  wire          loops_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire hit_direct = (reg_addr == `PIE_OFS_DIRECT);
  wire hit_set    = (reg_addr == `PIE_OFS_SET);
  wire hit_clear  = (reg_addr == `PIE_OFS_CLEAR);
  wire hit_status = (reg_addr == `PIE_OFS_STATUS);
  wire hit_loops  = (reg_addr == `PIE_OFS_LOOPS);

  wire wr_direct  = reg_wr && hit_direct;
  wire wr_set     = reg_wr && hit_set;
  wire wr_clear   = reg_wr && hit_clear;
  wire wr_loops   = reg_wr && hit_loops;

  // only the implemented event bits of a write are looked at
  assign wbits = reg_wdata[`PIE_BIT_HI:`PIE_BIT_LO];

  // a view's operand is zero unless that view is written this cycle
  assign set_bits   = wr_set   ? wbits : {NE{1'b0}};
  assign clear_bits = wr_clear ? wbits : {NE{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // looped playback completion

  pie_loop_tracker #(
    .LW (LW)
  ) u_loops (
    .mclk       (mclk),
    .rst        (rst),
    .play_start (playback_start),
    .seq1_done  (sequence_finished_event[1]),
    .loop_count (loop_count),
    .loops_done (loops_pulse)
  );

  assign loops_completed_event = loops_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // enable mask
  // one mask behind three views; the strobes never coincide, so the views
  // need no priority among themselves

  // per bit, a zero in a set or clear write leaves the bit as it was
  genvar b;
  generate
    for (b = 0; b < NE; b = b + 1) begin : g_mask
      reg mask_bit;
      reg next_mask_bit;

      always @* begin
        next_mask_bit = mask_bit;
        if (wr_direct)
          next_mask_bit = wbits[b];
        else if (set_bits[b])
          next_mask_bit = 1'b1;
        else if (clear_bits[b])
          next_mask_bit = 1'b0;
      end

      always @(posedge mclk) begin
        if (rst)
          mask_bit <= RST_ENABLE[b];
        else
          mask_bit <= next_mask_bit;
      end

      assign enable[b] = mask_bit;
    end
  endgenerate

  assign enable_state = enable;

  ////////////////////////////////////////////////////////////////////////////
  // repeat count used by the completion tracker

  always @(posedge mclk) begin
    if (rst)
      loop_count <= `PIE_RST_LOOPS;
    else if (wr_loops)
      loop_count <= reg_wdata[LW-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, cleared by reading it

  assign evt_vec[IX_HALTED]  = halted_event;
  assign evt_vec[IX_BEGUN0]  = sequence_begun_event[0];
  assign evt_vec[IX_BEGUN1]  = sequence_begun_event[1];
  assign evt_vec[IX_FINISH0] = sequence_finished_event[0];
  assign evt_vec[IX_FINISH1] = sequence_finished_event[1];
  assign evt_vec[IX_PERIOD]  = period_finished_event;
  assign evt_vec[IX_LOOPS]   = loops_pulse;

  assign status_read = reg_rd && hit_status;

  // events are recorded whether enabled or not; the mask only gates irq
  pie_event_latch #(
    .N (`PIE_NUM_EVT)
  ) u_status (
    .mclk  (mclk),
    .rst   (rst),
    .evt   (evt_vec),
    .clear (status_read),
    .flag  (status)
  );

  // an event recorded while masked raises irq as soon as it is enabled
  assign pending = status & enable;
  assign irq     = |pending;

  ////////////////////////////////////////////////////////////////////////////
  // read path: data stand for exactly the cycle after the strobe; the
  // direct, set and clear addresses all show the one live mask

  assign view_mask   = {{PAD_HI{1'b0}}, enable, {PAD_LO{1'b0}}};
  assign view_status = {{PAD_HI{1'b0}}, status, {PAD_LO{1'b0}}};
  assign view_loops  = {{PAD_LOOPS{1'b0}}, loop_count};

  always @* begin
    next_rdata = `PIE_RST_DATA;
    if (reg_rd) begin
      case (reg_addr)
        `PIE_OFS_DIRECT: next_rdata = view_mask;
        `PIE_OFS_SET:    next_rdata = view_mask;
        `PIE_OFS_CLEAR:  next_rdata = view_mask;
        `PIE_OFS_STATUS: next_rdata = view_status;
        `PIE_OFS_LOOPS:  next_rdata = view_loops;
        default:         next_rdata = `PIE_RST_DATA;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (rst)
      reg_rdata <= `PIE_RST_DATA;
    else
      reg_rdata <= next_rdata;
  end

endmodule // pie_top

// ---- testbench/pie_top_properties.sv ----
/* port checker of the interrupt enable block.
   assumes: bound to pie_top, single clock mclk, sync reset rst. */
`timescale 1ns/1ps
module pie_chk (
  input wire        mclk,
  input wire        rst,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        halted_event,
  input wire [1:0]  sequence_finished_event,
  input wire        loops_completed_event,
  input wire [6:0]  enable_state,
  input wire        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire mask_wr = reg_wr && (reg_addr == 12'h300 || reg_addr == 12'h304 ||
    reg_addr == 12'h308);
  //////////////////////////////////////////////////////////////////////////
  AST_SET_VIEW:
    assert property (reg_wr && reg_addr == 12'h304 |=> enable_state ==
      ($past(enable_state) | $past(reg_wdata[7:1]))) else $error("set view wrong");
  AST_CLR_VIEW:
    assert property (reg_wr && reg_addr == 12'h308 |=> enable_state ==
      ($past(enable_state) & ~$past(reg_wdata[7:1]))) else $error("clear view wrong");
  AST_DIRECT:
    assert property (reg_wr && reg_addr == 12'h300 |=> enable_state == $past(reg_wdata[7:1]))
      else $error("direct write wrong");
  AST_READBACK:
    assert property (reg_rd && (reg_addr == 12'h304 || reg_addr == 12'h308) |=>
      reg_rdata == {24'h0, $past(enable_state), 1'b0}) else $error("readback wrong");
  AST_HOLD:
    assert property (!mask_wr |=> $stable(enable_state)) else $error("mask moved");
  AST_IRQ_MASK:
    assert property (irq |-> enable_state != 7'h00) else $error("irq while masked");
  AST_IRQ_RAISE:
    assert property (halted_event && enable_state[0] && !reg_wr |=> irq)
      else $error("irq missing");
  AST_LOOP_CAUSE:
    assert property (loops_completed_event |-> $past(sequence_finished_event[1]))
      else $error("loop event without finish");
  AST_LOOP_PULSE:
    assert property (loops_completed_event |=> !loops_completed_event)
      else $error("loop event too long");
  cover property (loops_completed_event);
  cover property (irq && reg_rd && reg_addr == 12'h30C);
  cover property (reg_wr && reg_addr == 12'h300);
endmodule // pie_chk
bind pie_top pie_chk pie_chk_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .halted_event(halted_event), .sequence_finished_event(sequence_finished_event),
  .loops_completed_event(loops_completed_event), .enable_state(enable_state), .irq(irq));

// ---- testbench/pie_top_tb.sv ----
/* self-checking bench of the interrupt enable block.
   assumes: pie_top and the checker are compiled alongside. */
`timescale 1ns/1ps
module pie_top_tb;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] reg_addr = 12'h000;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [6:0]  evt = 7'h00;
  wire [31:0] reg_rdata;
  wire        loops_completed_event;
  wire [6:0]  enable_state;
  wire        irq;
  integer     err_total = 0;
  integer     compares = 0;
  integer     i;
  pie_top pie_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halted_event(evt[0]),
    .sequence_begun_event(evt[2:1]), .sequence_finished_event(evt[4:3]),
    .period_finished_event(evt[5]), .playback_start(evt[6]),
    .loops_completed_event(loops_completed_event), .enable_state(enable_state), .irq(irq));
  initial forever #10 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [11:0] a, input [31:0] exp);
    begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
    end
  endtask
  // bit order: halted, begun 1:0, finished 1:0, period, playback start
  task ev(input [6:0] v);
    begin
      @(posedge mclk);
      evt <= v;
      @(posedge mclk);
      evt <= 7'h00;
      #1;
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_total = err_total + 1;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(12'h304, 32'h0);
    rd(12'h308, 32'h0);
    $display("test reset values done");
    for (i = 1; i < 8; i = i + 1) begin
      wr(12'h304, 32'h1 << i);
      rd(12'h308, (32'h2 << i) - 32'h2);
    end
    wr(12'h304, 32'h0);
    wr(12'h308, 32'h0);
    rd(12'h304, 32'hFE);
    for (i = 1; i < 8; i = i + 1)
      wr(12'h308, 32'h1 << i);
    rd(12'h304, 32'h0);
    wr(12'h300, 32'hFFFFFFFF);
    rd(12'h308, 32'hFE);
    wr(12'h300, 32'h54);
    rd(12'h304, 32'h54);
    chk(enable_state, 32'h2A);
    rd(12'h300, 32'h54);
    @(posedge mclk) #1 chk(reg_rdata, 32'h0);
    rd(12'h31C, 32'h0);
    $display("test enable views done");
    wr(12'h300, 32'hFE);
    for (i = 0; i < 6; i = i + 1) begin
      ev(7'h01 << i);
      chk(irq, 1'b1);
      rd(12'h30C, 32'h2 << i);
      chk(irq, 1'b0);
    end
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= 12'h30C;
    evt <= 7'h20;
    @(posedge mclk);
    reg_rd <= 1'b0;
    evt <= 7'h00;
    #1 chk(reg_rdata, 32'h0);
    chk(irq, 1'b1);
    rd(12'h30C, 32'h40);
    wr(12'h308, 32'h2);
    ev(7'h01);
    chk(irq, 1'b0);
    rd(12'h30C, 32'h2);
    $display("test interrupt done");
    wr(12'h310, 32'h2);
    rd(12'h310, 32'h2);
    ev(7'h40);
    ev(7'h10);
    chk(loops_completed_event, 1'b0);
    ev(7'h10);
    chk(loops_completed_event, 1'b1);
    rd(12'h30C, 32'hA0);
    wr(12'h310, 32'h0);
    ev(7'h40);
    ev(7'h10);
    chk(loops_completed_event, 1'b0);
    rd(12'h30C, 32'h20);
    $display("test loop tracking done");
    wr(12'h300, 32'hFE);
    wr(12'h310, 32'h3);
    ev(7'h01);
    chk(irq, 1'b1);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 chk(irq, 1'b0);
    chk(enable_state, 32'h0);
    rd(12'h304, 32'h0);
    rd(12'h30C, 32'h0);
    rd(12'h310, 32'h0);
    $display("test mid-run reset done");
    finish_test;
  end
endmodule // pie_top_tb
